// ---- rtl/pbt_lane_mask.sv ----
// lane coverage of one destination word
// assumes pointer offset and remaining width from the sequencer
`timescale 1ns/1ps
`default_nettype none
module pbt_lane_mask (
	// word position
	input  wire logic [3:0]  OFF_IN,
	input  wire logic [2:0]  LOG_IN,
	input  wire logic [15:0] XREM_IN,
	// coverage
	output logic [4:0]       P0_OUT,
	output logic [4:0]       CNT_OUT,
	output logic [4:0]       NBITS_OUT,
	output logic [15:0]      MASK_OUT
);
	logic [4:0] ppw;
	logic [4:0] avail;

	// pixels from the offset to word end, capped by row remainder
	assign P0_OUT = {1'b0, OFF_IN} >> LOG_IN;
	assign ppw = 5'h10 >> LOG_IN;
	assign avail = ppw - P0_OUT;
	assign CNT_OUT = (XREM_IN < {11'h000, avail}) ? XREM_IN[4:0] : avail;
	assign NBITS_OUT = CNT_OUT << LOG_IN;
	assign MASK_OUT = 16'(((17'h00001 << NBITS_OUT) - 17'h00001) << OFF_IN);
endmodule // pbt_lane_mask
`default_nettype wire

// ---- rtl/pbt_pixel_unit.sv ----
// expansion, pixel operation, transparency and plane mask for one word
// assumes lane-aligned source bits and a captured destination word
`timescale 1ns/1ps
`default_nettype none
module pbt_pixel_unit (
	// operands
	input  wire logic [15:0] BITS_IN,
	input  wire logic [15:0] FG_IN,
	input  wire logic [15:0] BG_IN,
	input  wire logic [15:0] DEST_IN,
	// controls
	input  wire logic [4:0]  OP_IN,
	input  wire logic        TRANSP_IN,
	input  wire logic [2:0]  LOG_IN,
	input  wire logic [15:0] PLANE_MASK_IN,
	input  wire logic [15:0] WMASK_IN,
	// result
	output logic [15:0]      WDATA_OUT
);
	logic [15:0] sel, src, bres, res, wm, keep;
	logic [3:0]  tt;
	logic        arith_ok;

	// each bit drives its whole lane before any operation
	always_comb begin
		sel = 16'h0000;
		for (int b = 0; b < 16; b++)
			sel[b] = BITS_IN[b >> LOG_IN];
	end
	assign src = (sel & FG_IN) | (~sel & BG_IN);
	// truth table indexed by {s,d}
	assign tt = OP_IN[3:0] ^ pbt_pkg::BOOL_BIAS;
	always_comb begin
		bres = 16'h0000;
		for (int b = 0; b < 16; b++)
			bres[b] = tt[{src[b], DEST_IN[b]}];
	end
	// tiny pixels have no carry room; fall back to boolean
	assign arith_ok = OP_IN[4] && LOG_IN >= 3'h2;
	assign res = arith_ok ? pbt_pkg::arith(src, DEST_IN, OP_IN[2:0], LOG_IN)
		: bres;
	// zero test on the processed result
	assign wm = TRANSP_IN ? WMASK_IN & ~pbt_pkg::zero_lanes(res, LOG_IN)
		: WMASK_IN;
	assign keep = ~wm | PLANE_MASK_IN;
	assign WDATA_OUT = (res & ~keep) | (DEST_IN & keep);
endmodule // pbt_pixel_unit
`default_nettype wire

// ---- rtl/pbt_transfer.sv ----
// binary-to-linear pixel block transfer sequencer with register port
// assumes memory acknowledges each request; processor raises irq level
`timescale 1ns/1ps
`default_nettype none
module pbt_transfer (
	// clock and reset
	input  wire logic                  CLK_IN,
	input  wire logic                  RST_N_IN,
	// register port
	input  wire pbt_pkg::pbt_reg_req_t REG_REQ_IN,
	output logic [31:0]                REG_RDATA_OUT,
	// local video memory
	output var pbt_pkg::pbt_mem_req_t  MEM_REQ_OUT,
	input  wire logic                  MEM_ACK_IN,
	input  wire logic [31:0]           MEM_RDATA_IN,
	// interrupt handshake
	input  wire logic                  IRQ_IN,
	output logic                       STACK_PUSH_OUT,
	output logic [31:0]                STACK_DATA_OUT,
	output logic                       BUSY_OUT
);
	pbt_pkg::pbt_state_t   state_q;
	pbt_pkg::pbt_mem_req_t mem_q;
	logic [31:0] sptr_q, dptr_q, sstr_q, dstr_q, dims_q, bg_q, fg_q;
	logic [31:0] drow_q, srow_q, buf_q, base_q, rdata_q, stack_q;
	logic [15:0] plane_mask_q, xrem_q, yrem_q, dest_q;
	logic [4:0]  op_q, pixel_size_q;
	logic        transp_q, srt_q, flag_q, buf_v_q, push_q;

	logic        sw_ok, wr, rd, go, return_from_interrupt, return_from_subroutine, need_src, row_end;
	logic [2:0]  lg;
	logic [4:0]  p0, cnt, nbits;
	logic [5:0]  soff;
	logic [15:0] wmask, lane_bits, wdata, fg_w, bg_w;
	logic [31:0] dword, stat_w, rd_w, wd, drow_n, srow_n;
	logic [3:0]  ra;

	// software may write registers only while stopped or paused; reads are taken at any time
	assign sw_ok = state_q == pbt_pkg::S_IDLE
		|| state_q == pbt_pkg::S_PAUSE;
	assign wr = REG_REQ_IN.we && sw_ok;
	assign rd = REG_REQ_IN.re;
	assign ra = REG_REQ_IN.addr;
	assign wd = REG_REQ_IN.wdata;
	assign go = wr && ra == pbt_pkg::R_CMD && wd[pbt_pkg::CMD_GO];
	assign return_from_interrupt = wr && ra == pbt_pkg::R_CMD && wd[pbt_pkg::CMD_RETURN_FROM_INTERRUPT];
	assign return_from_subroutine = wr && ra == pbt_pkg::R_CMD && wd[pbt_pkg::CMD_RETURN_FROM_SUBROUTINE];

	// word geometry; transfer walks upward only
	assign lg = pbt_pkg::size_log(pixel_size_q);
	assign dword = {dptr_q[31:4], 4'h0};
	assign soff = 6'(sptr_q - base_q);
	assign need_src = !buf_v_q
		|| {1'b0, soff} + {2'b00, cnt} > pbt_pkg::SRC_GROUP;
	assign lane_bits = 16'((buf_q >> soff) << p0);
	assign fg_w = dword[4] ? fg_q[31:16] : fg_q[15:0];
	assign bg_w = dword[4] ? bg_q[31:16] : bg_q[15:0];
	assign row_end = xrem_q == 16'h0000;
	assign drow_n = drow_q + dstr_q;
	assign srow_n = srow_q + sstr_q;

	pbt_lane_mask u_lane (
		.OFF_IN    (dptr_q[3:0]),
		.LOG_IN    (lg),
		.XREM_IN   (xrem_q),
		.P0_OUT    (p0),
		.CNT_OUT   (cnt),
		.NBITS_OUT (nbits),
		.MASK_OUT  (wmask)
	);

	pbt_pixel_unit u_pix (
		.BITS_IN   (lane_bits),
		.FG_IN     (fg_w),
		.BG_IN     (bg_w),
		.DEST_IN   (dest_q),
		.OP_IN     (op_q),
		.TRANSP_IN (transp_q),
		.LOG_IN    (lg),
		.PLANE_MASK_IN  (plane_mask_q),
		.WMASK_IN  (wmask),
		.WDATA_OUT (wdata)
	);

	// configuration registers
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			sstr_q <= 32'h00000000;
			dstr_q <= 32'h00000000;
			dims_q <= 32'h00000000;
			bg_q <= 32'h00000000;
			fg_q <= 32'h00000000;
			op_q <= pbt_pkg::OP_RST;
			transp_q <= 1'b0;
			pixel_size_q <= pbt_pkg::PIXEL_SIZE_RST;
			plane_mask_q <= pbt_pkg::PLANE_MASK_RST;
			srt_q <= 1'b0;
		end else if (wr) begin
			case (ra)
				pbt_pkg::R_SSTR: sstr_q <= wd;
				pbt_pkg::R_DSTR: dstr_q <= wd;
				pbt_pkg::R_DIMS: dims_q <= wd;
				pbt_pkg::R_BG: bg_q <= wd;
				pbt_pkg::R_FG: fg_q <= wd;
				pbt_pkg::R_CTRL: begin
					op_q <= wd[pbt_pkg::OP_MSB:pbt_pkg::OP_LSB];
					transp_q <= wd[pbt_pkg::TRANSP_BIT];
				end
				pbt_pkg::R_PIXEL_SIZE: pixel_size_q <= wd[4:0];
				pbt_pkg::R_PLANE_MASK: plane_mask_q <= wd[15:0];
				pbt_pkg::R_DISP: srt_q <= wd[pbt_pkg::SRT_BIT];
				default: ;
			endcase
		end
	end

	// sequencer; pointers double as the software-visible registers
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			state_q <= pbt_pkg::S_IDLE;
			mem_q <= '0;
			sptr_q <= 32'h00000000;
			dptr_q <= 32'h00000000;
			drow_q <= 32'h00000000;
			srow_q <= 32'h00000000;
			buf_q <= 32'h00000000;
			base_q <= 32'h00000000;
			xrem_q <= 16'h0000;
			yrem_q <= 16'h0000;
			dest_q <= 16'h0000;
			flag_q <= 1'b0;
			buf_v_q <= 1'b0;
		end else begin
			if (wr && ra == pbt_pkg::R_SPTR)
				sptr_q <= wd;
			if (wr && ra == pbt_pkg::R_DPTR)
				dptr_q <= wd;
			case (state_q)
				pbt_pkg::S_IDLE: begin
					if (go && dims_q[31:16] != 16'h0000
						&& dims_q[15:0] != 16'h0000) begin
						drow_q <= dptr_q;
						srow_q <= sptr_q;
						xrem_q <= dims_q[15:0];
						yrem_q <= dims_q[31:16];
						buf_v_q <= 1'b0;
						state_q <= pbt_pkg::S_WORD;
					end
				end
				pbt_pkg::S_WORD: begin
					state_q <= need_src ? pbt_pkg::S_SRC : pbt_pkg::S_DRD;
				end
				pbt_pkg::S_SRC: begin
					if (!mem_q.req) begin
						mem_q <= '{1'b1, 1'b0, srt_q, sptr_q, 16'h0000};
					end else if (MEM_ACK_IN) begin
						mem_q.req <= 1'b0;
						buf_q <= MEM_RDATA_IN;
						base_q <= sptr_q;
						buf_v_q <= 1'b1;
						state_q <= pbt_pkg::S_DRD;
					end
				end
				pbt_pkg::S_DRD: begin
					if (!mem_q.req) begin
						mem_q <= '{1'b1, 1'b0, srt_q, dword, 16'h0000};
					end else if (MEM_ACK_IN) begin
						mem_q.req <= 1'b0;
						dest_q <= MEM_RDATA_IN[15:0];
						state_q <= pbt_pkg::S_DWR;
					end
				end
				pbt_pkg::S_DWR: begin
					if (!mem_q.req) begin
						mem_q <= '{1'b1, 1'b1, srt_q, dword, wdata};
					end else if (MEM_ACK_IN) begin
						mem_q.req <= 1'b0;
						dptr_q <= dptr_q + {27'h0000000, nbits};
						sptr_q <= sptr_q + {27'h0000000, cnt};
						xrem_q <= xrem_q - {11'h000, cnt};
						state_q <= pbt_pkg::S_NEXT;
					end
				end
				pbt_pkg::S_NEXT: begin
					// only boundary at which an interrupt is taken
					state_q <= IRQ_IN ? pbt_pkg::S_INTR
						: pbt_pkg::S_WORD;
					if (row_end) begin
						drow_q <= drow_n;
						srow_q <= srow_n;
						dptr_q <= drow_n;
						sptr_q <= srow_n;
						xrem_q <= dims_q[15:0];
						yrem_q <= yrem_q - 16'h0001;
						buf_v_q <= 1'b0;
						if (yrem_q == 16'h0001)
							state_q <= pbt_pkg::S_IDLE;
					end
				end
				pbt_pkg::S_INTR: begin
					flag_q <= 1'b1;
					state_q <= pbt_pkg::S_PAUSE;
				end
				pbt_pkg::S_PAUSE: begin
					// restored registers are trusted on return
					if (return_from_interrupt) begin
						flag_q <= 1'b0;
						buf_v_q <= 1'b0;
						state_q <= pbt_pkg::S_WORD;
					end else if (return_from_subroutine) begin
						flag_q <= 1'b0;
						state_q <= pbt_pkg::S_IDLE;
					end
				end
				default: state_q <= pbt_pkg::S_IDLE;
			endcase
		end
	end

	// status push on the same edge that sets the flag
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			push_q <= 1'b0;
			stack_q <= 32'h00000000;
		end else begin
			push_q <= state_q == pbt_pkg::S_INTR;
			if (state_q == pbt_pkg::S_INTR)
				stack_q <= stat_w | 32'h00000002;
		end
	end

	// no arithmetic flags are kept; upper bits read zero
	assign stat_w = {29'h00000000, state_q == pbt_pkg::S_PAUSE, flag_q,
		!sw_ok};
	// read selection; unmapped and command read zero
	assign rd_w = (ra == pbt_pkg::R_SPTR) ? sptr_q
		: (ra == pbt_pkg::R_DPTR) ? dptr_q
		: (ra == pbt_pkg::R_SSTR) ? sstr_q
		: (ra == pbt_pkg::R_DSTR) ? dstr_q
		: (ra == pbt_pkg::R_DIMS) ? dims_q
		: (ra == pbt_pkg::R_BG) ? bg_q
		: (ra == pbt_pkg::R_FG) ? fg_q
		: (ra == pbt_pkg::R_CTRL) ? {17'h00000, op_q, 4'h0, transp_q,
			5'h00}
		: (ra == pbt_pkg::R_PIXEL_SIZE) ? {27'h0000000, pixel_size_q}
		: (ra == pbt_pkg::R_PLANE_MASK) ? {16'h0000, plane_mask_q}
		: (ra == pbt_pkg::R_DISP) ? {31'h00000000, srt_q}
		: (ra == pbt_pkg::R_STAT) ? stat_w
		: (ra == pbt_pkg::R_SCR0) ? {yrem_q, xrem_q}
		: (ra == pbt_pkg::R_SCR1) ? drow_q
		: (ra == pbt_pkg::R_SCR2) ? srow_q
		: 32'h00000000;

	// read data one cycle after the strobe
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN)
			rdata_q <= 32'h00000000;
		else
			rdata_q <= rd ? rd_w : 32'h00000000;
	end

	assign REG_RDATA_OUT = rdata_q;
	assign MEM_REQ_OUT = mem_q;
	assign STACK_PUSH_OUT = push_q;
	assign STACK_DATA_OUT = stack_q;
	assign BUSY_OUT = !sw_ok;

	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);

	a_irq_boundary: assert property (state_q == pbt_pkg::S_INTR
		|-> $past(state_q) == pbt_pkg::S_NEXT)
		else $error("interrupt taken off a boundary");
	a_flag_then_push: assert property (push_q
		|-> flag_q && stack_q[pbt_pkg::ST_FLAG]
		&& $past(state_q) == pbt_pkg::S_INTR)
		else $error("status pushed without flag");
	a_srt_all_cycles: assert property (mem_q.req
		|-> mem_q.shift_transfer_enable == srt_q)
		else $error("memory cycle lost shift-transfer mark");
	a_reset_replace: assert property ($rose(RST_N_IN)
		|-> op_q == 5'h00 && !transp_q)
		else $error("reset defaults wrong");
	a_plane_kept: assert property (mem_q.req && mem_q.we
		|-> ((mem_q.wdata ^ dest_q) & plane_mask_q) == 16'h0000)
		else $error("masked plane modified");
	a_addr_rises: assert property (state_q == pbt_pkg::S_DWR
		&& mem_q.req && MEM_ACK_IN |=> dptr_q > $past(dptr_q))
		else $error("destination pointer did not advance");
	a_done_rowstart: assert property (state_q == pbt_pkg::S_NEXT
		&& row_end && yrem_q == 16'h0001 |=> state_q == pbt_pkg::S_IDLE
		&& dptr_q == drow_q && sptr_q == srow_q)
		else $error("completion pointers wrong");
	a_return_from_subroutine_abandon: assert property (state_q == pbt_pkg::S_PAUSE
		&& return_from_subroutine && !return_from_interrupt |=> state_q == pbt_pkg::S_IDLE && !flag_q)
		else $error("abandon did not stop transfer");
	a_row_reload: assert property (state_q == pbt_pkg::S_NEXT
		&& row_end && yrem_q > 16'h0001 |=> xrem_q == dims_q[15:0])
		else $error("row width not reloaded");
	a_word_aligned: assert property (mem_q.req && mem_q.we
		|-> mem_q.addr[3:0] == 4'h0 && mem_q.addr == dword)
		else $error("unaligned destination write");

	c_done: cover property (state_q == pbt_pkg::S_NEXT
		##1 state_q == pbt_pkg::S_IDLE);
	c_pause: cover property (push_q ##[1:20] return_from_interrupt);
	c_abandon: cover property (state_q == pbt_pkg::S_PAUSE && return_from_subroutine);
	c_srt_write: cover property (mem_q.req && mem_q.we && mem_q.shift_transfer_enable);
endmodule // pbt_transfer
`default_nettype wire

// ---- shared/pbt_pkg.sv ----
// constants, types and helpers for the binary-expand pixel block transfer
// assumes one 20 MHz clock, synchronous active-low reset
// Functional notes
// - expand source bits, then apply pixel operation
// - no arithmetic operations at one or two bits
// - transparency skips writing zero pixels
// - zero test on processed result, not source
// - reset: transparency off, operation is replace
// - plane mask protects masked destination bit planes
// - interrupt only at word or row boundary
// - set interrupted flag, then push status word
// - scratch registers hold resume state when interrupted
// - destination pointer names next word to modify
// - source pointer names next 32-pixel source group
// - subroutine return abandons, scratch then indeterminate
// - shift-transfer enable marks every memory cycle
// - negative, carry, zero, overflow flags undefined
// - control 0x4800 selects destination minus source
// - one bits pick foreground, zero bits background
// - no corner adjust or window, increasing address
// - completion leaves pointers at next row start
package pbt_pkg;
	// register index map
	localparam logic [3:0] R_SPTR = 4'h0, R_DPTR = 4'h1;
	localparam logic [3:0] R_SSTR = 4'h2, R_DSTR = 4'h3;
	localparam logic [3:0] R_DIMS = 4'h4, R_BG = 4'h5, R_FG = 4'h6;
	localparam logic [3:0] R_CTRL = 4'h7, R_PIXEL_SIZE = 4'h8;
	localparam logic [3:0] R_PLANE_MASK = 4'h9, R_DISP = 4'hA;
	localparam logic [3:0] R_STAT = 4'hB, R_CMD = 4'hC;
	localparam logic [3:0] R_SCR0 = 4'hD, R_SCR1 = 4'hE;
	localparam logic [3:0] R_SCR2 = 4'hF;
	// field positions
	localparam int OP_LSB = 10, OP_MSB = 14, TRANSP_BIT = 5;
	localparam int SRT_BIT = 0;
	localparam int ST_BUSY = 0, ST_FLAG = 1, ST_PAUSE = 2;
	localparam int CMD_GO = 0, CMD_RETURN_FROM_INTERRUPT = 1, CMD_RETURN_FROM_SUBROUTINE = 2;
	// reset values
	localparam logic [4:0] OP_RST = 5'h00;
	localparam logic [4:0] PIXEL_SIZE_RST = 5'h10;
	localparam logic [15:0] PLANE_MASK_RST = 16'h0000;
	// boolean truth table bias: code zero gives replace
	localparam logic [3:0] BOOL_BIAS = 4'hC;
	localparam logic [6:0] SRC_GROUP = 7'h20;
	// arithmetic sub-codes in op[2:0]
	localparam logic [2:0] A_ADD = 3'h0, A_ADDS = 3'h1, A_SUB = 3'h2;
	localparam logic [2:0] A_SUBS = 3'h3, A_MAX = 3'h4, A_MIN = 3'h5;
	typedef enum logic [7:0] {
		S_IDLE = 8'h01, S_WORD = 8'h02, S_SRC = 8'h04, S_DRD = 8'h08,
		S_DWR = 8'h10, S_NEXT = 8'h20, S_INTR = 8'h40, S_PAUSE = 8'h80
	} pbt_state_t;
	typedef struct packed {
		logic        we;
		logic        re;
		logic [3:0]  addr;
		logic [31:0] wdata;
	} pbt_reg_req_t;
	typedef struct packed {
		logic        req;
		logic        we;
		logic        shift_transfer_enable;
		logic [31:0] addr;
		logic [15:0] wdata;
	} pbt_mem_req_t;
	// pixel size in bits to log2; values other than 1, 2, 4 and 8 fall back to 16
	function automatic logic [2:0] size_log(input logic [4:0] s);
		case (s)
			5'h01: size_log = 3'h0;
			5'h02: size_log = 3'h1;
			5'h04: size_log = 3'h2;
			5'h08: size_log = 3'h3;
			default: size_log = 3'h4;
		endcase
	endfunction
	// per-lane arithmetic on a 16-bit word of 2**lg-bit pixels
	function automatic logic [15:0] arith(input logic [15:0] s, d,
		input logic [2:0] op, input logic [2:0] lg);
		logic [15:0] r;
		logic [16:0] m, a, b, t;
		int w;
		r = 16'h0000;
		w = 1 << lg;
		m = (17'h00001 << w) - 17'h00001;
		for (int i = 0; i < 16; i++) begin
			a = ({1'b0, s} >> i) & m;
			b = ({1'b0, d} >> i) & m;
			case (op)
				A_ADD: t = a + b;
				A_ADDS: t = (a + b > m) ? m : a + b;
				A_SUB: t = b - a;
				A_SUBS: t = (b < a) ? 17'h00000 : b - a;
				A_MAX: t = (a > b) ? a : b;
				A_MIN: t = (a < b) ? a : b;
				default: t = a;
			endcase
			if (i % w == 0)
				r = r | 16'((t & m) << i);
		end
		return r;
	endfunction
	// mask of all bits whose pixel lane is zero
	function automatic logic [15:0] zero_lanes(input logic [15:0] v,
		input logic [2:0] lg);
		logic [15:0] z, m;
		int w;
		z = 16'h0000;
		w = 1 << lg;
		m = 16'((17'h00001 << w) - 17'h00001);
		for (int i = 0; i < 16; i++)
			if (i % w == 0 && ((v >> i) & m) == 16'h0000)
				z = z | 16'(m << i);
		return z;
	endfunction
endpackage

// ---- tb/pbt_mem_model.sv ----
// video memory model: 16-bit words, bit addresses, random ack delay
// assumes requests held until ack; bench may preload mem directly
`timescale 1ns/1ps
`default_nettype none
module pbt_mem_model (
	// clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  rst_n_in,
	// memory link
	input  wire pbt_pkg::pbt_mem_req_t req_in,
	output logic                       ack_out,
	output logic [31:0]                rdata_out
);
	logic [15:0] mem [0:4095];
	logic [1:0]  cnt_q;
	logic [1:0]  wait_q;
	logic [11:0] w;
	logic [47:0] win;
	logic [31:0] val;
	// three words so any bit offset still yields 32 source bits
	assign w = req_in.addr[15:4];
	assign win = {mem[w + 12'h002], mem[w + 12'h001], mem[w]};
	assign val = 32'(win >> req_in.addr[3:0]);
	// zero-wait ack allowed; idle data shows the inverse, not a stale copy
	assign ack_out = req_in.req && cnt_q == wait_q;
	assign rdata_out = ack_out ? val : ~val;
	// plain always: the bench also preloads mem
	always @(posedge clk_in) begin
		if (!rst_n_in || ack_out) begin
			cnt_q <= 2'h0;
			wait_q <= 2'($urandom % 3);
		end else if (req_in.req)
			cnt_q <= cnt_q + 2'h1;
		if (ack_out && req_in.we)
			mem[w] <= req_in.wdata;
	end
endmodule // pbt_mem_model
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the binary-expand block transfer
// assumes pbt_mem_model on the memory side, registers 0..10 as mapped
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic                  clk;
	logic                  rst_n;
	logic                  irq;
	logic                  ack;
	logic                  push;
	logic                  busy;
	logic [31:0]           mrd;
	logic [31:0]           rdata;
	logic [31:0]           sdata;
	pbt_pkg::pbt_reg_req_t rq;
	pbt_pkg::pbt_mem_req_t mreq;
	logic [15:0]           exp [0:4095];
	logic [31:0]           sp, dp, ss, ds, fg, bg, last_wr, v;
	logic [15:0]           pm;
	logic [4:0]            op, psz;
	logic                  tr, shift_transfer_enable;
	int                    rows, cols, miscompares, n_compared, n_wr;
	// design and memory partner
	pbt_transfer dut (.CLK_IN(clk), .RST_N_IN(rst_n), .REG_REQ_IN(rq),
		.REG_RDATA_OUT(rdata), .MEM_REQ_OUT(mreq), .MEM_ACK_IN(ack),
		.MEM_RDATA_IN(mrd), .IRQ_IN(irq), .STACK_PUSH_OUT(push),
		.STACK_DATA_OUT(sdata), .BUSY_OUT(busy));
	pbt_mem_model mem (.clk_in(clk), .rst_n_in(rst_n), .req_in(mreq),
		.ack_out(ack), .rdata_out(mrd));
	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input logic ok, input string msg);
		n_compared++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask
	// one-cycle strobes, changed just after the edge
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		rq <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		rq <= '0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		rq <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 32'h0};
		@(posedge clk);
		rq <= '0;
		#1;
		d = rdata;
	endtask
	// bounded wait for idle or for the stack push
	task automatic wait_on(input bit for_push);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			if (++n > 20000) begin
				check(1'b0, "wait timed out");
				finish_test();
			end
		end while (for_push ? push !== 1'b1 : (n < 3 || busy !== 1'b0));
	endtask
	// pixel operation on one aligned pixel of psz bits
	function automatic logic [16:0] alu(input logic [16:0] s, d);
		logic [16:0] m, r;
		logic [3:0]  tt;
		m = (17'h1 << psz) - 17'h1;
		tt = op[3:0] ^ 4'hC;
		r = 17'h0;
		if (op[4] && psz > 5'h2)
			case (op[2:0])
				3'h0: r = s + d;
				3'h1: r = (s + d > m) ? m : s + d;
				3'h2: r = d - s;
				3'h3: r = (d < s) ? 17'h0 : d - s;
				3'h4: r = (s > d) ? s : d;
				3'h5: r = (s < d) ? s : d;
				default: r = s;
			endcase
		else
			for (int i = 0; i < 16; i++)
				r[i] = tt[{s[i], d[i]}];
		return r & m;
	endfunction
	// expected destination after a whole transfer
	task automatic model_xfer();
		logic [31:0] a, b;
		logic [16:0] m, s, d, k, r;
		m = (17'h1 << psz) - 17'h1;
		for (int y = 0; y < rows; y++)
			for (int x = 0; x < cols; x++) begin
				a = dp + 32'(y) * ds + 32'(x) * 32'(psz);
				b = sp + 32'(y) * ss + 32'(x);
				s = 17'((exp[b[15:4]][b[3:0]] ? fg : bg) >> a[4:0]) & m;
				d = 17'(exp[a[15:4]] >> a[3:0]) & m;
				k = 17'(pm >> a[3:0]) & m;
				r = alu(s, d);
				if (!(tr && r == 17'h0)) begin
					r = (r & ~k) | (d & k);
					exp[a[15:4]] = (exp[a[15:4]] & ~16'(m << a[3:0]))
						| 16'(r << a[3:0]);
				end
			end
	endtask
	// random setup, start, then a write that busy must drop
	task automatic setup(input logic [4:0] o, input int p);
		logic [31:0] cfg [11];
		op = o;
		psz = p ? 5'(p) : 5'h1 << ($urandom % 5);
		rows = 1 + $urandom % 3;
		cols = p ? 40 : 1 + $urandom % 40;
		sp = $urandom % 32'h1000;
		ss = 32'(cols) + $urandom % 64;
		dp = 32'h4000 + ($urandom % 256) * 32'(psz);
		ds = 32'((cols * psz) / 16 + 2 + $urandom % 4) * 32'h10;
		tr = (o != 5'h12) && ($urandom % 2);
		pm = ($urandom % 2) ? 16'($urandom) : 16'h0;
		shift_transfer_enable = 1'($urandom);
		fg = $urandom;
		bg = ($urandom % 2) ? 32'h0 : $urandom;
		last_wr = 32'h0;
		n_wr = 0;
		for (int w = 0; w < 4096; w++) begin
			mem.mem[w] = 16'($urandom);
			exp[w] = mem.mem[w];
		end
		cfg = '{sp, dp, ss, ds, {16'(rows), 16'(cols)}, bg, fg,
			{17'h0, o, 4'h0, tr, 5'h0}, 32'(psz), 32'(pm), 32'(shift_transfer_enable)};
		for (int i = 0; i < 11; i++)
			wr(4'(i), cfg[i]);
		wr(pbt_pkg::R_CMD, 32'h1);
		wr(pbt_pkg::R_PLANE_MASK, 32'(~pm));
	endtask
	task automatic check_end();
		int bad;
		bad = 0;
		model_xfer();
		for (int w = 0; w < 4096; w++)
			bad += (mem.mem[w] !== exp[w]);
		check(bad == 0, "destination contents");
		rd(pbt_pkg::R_SPTR, v);
		check(v === sp + 32'(rows) * ss, "source pointer at end");
		rd(pbt_pkg::R_DPTR, v);
		check(v === dp + 32'(rows) * ds, "dest pointer at end");
		rd(pbt_pkg::R_PLANE_MASK, v);
		check(v === 32'(pm), "write while busy kept out");
		rd(pbt_pkg::R_CTRL, v);
		check(v === {17'h0, op, 4'h0, tr, 5'h0}, "control word");
	endtask
	// pause mid-transfer, then resume or abandon
	task automatic irq_test(input logic [31:0] cmd);
		logic [31:0] nr, nc;
		setup(5'h00, 16);
		repeat (30) @(posedge clk);
		irq <= 1'b1;
		wait_on(1'b1);
		@(posedge clk);
		irq <= 1'b0;
		check(sdata[1] === 1'b1, "pushed status flag");
		rd(pbt_pkg::R_STAT, v);
		check(v[2:0] === 3'h6, "paused status");
		// one pixel per word here, so counted writes are pixels done
		nr = 32'(n_wr / cols);
		nc = 32'(n_wr % cols);
		rd(pbt_pkg::R_DPTR, v);
		check(v[3:0] === 4'h0 && v > dp, "pause at word");
		check(v === dp + nr * ds + nc * 32'h10, "dest next word");
		rd(pbt_pkg::R_SPTR, v);
		check(v >= sp, "source pointer in range");
		check(v === sp + nr * ss + nc, "source next group");
		rd(pbt_pkg::R_SCR0, v);
		check(v === {16'(32'(rows) - nr), 16'(32'(cols) - nc)},
			"rows and columns left");
		rd(pbt_pkg::R_SCR1, v);
		check(v === dp + nr * ds, "dest row start");
		wr(pbt_pkg::R_CMD, cmd);
		wait_on(1'b0);
		if (cmd == 32'h2)
			check_end();
		rd(pbt_pkg::R_STAT, v);
		check(v[2:0] === 3'h0, "idle after return");
	endtask
	// every acknowledged access: shift mark and write order
	always @(posedge clk)
		if (rst_n && mreq.req && ack) begin
			check(mreq.shift_transfer_enable === shift_transfer_enable, "shift transfer mark");
			if (mreq.we) begin
				check(mreq.addr > last_wr && mreq.addr[3:0] === 4'h0,
					"write order");
				last_wr <= mreq.addr;
				n_wr <= n_wr + 1;
			end
		end
	// main sequence
	initial begin
		rst_n = 1'b0;
		irq = 1'b0;
		rq = '0;
		shift_transfer_enable = 1'b0;
		void'($urandom(56720));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd(pbt_pkg::R_CTRL, v);
		check(v === 32'h0, "control after reset");
		rd(pbt_pkg::R_PIXEL_SIZE, v);
		check(v === 32'h10, "pixel size after reset");
		rd(pbt_pkg::R_CMD, v);
		check(v === 32'h0, "command reads zero");
		// codes 0 to 23, then arithmetic at two bits and at eight bits
		for (int t = 0; t < 36; t++) begin
			setup(t < 24 ? 5'(t) : 5'(16 + (t - 24) % 6),
				t < 24 ? 0 : (t < 30 ? 2 : 8));
			wait_on(1'b0);
			check_end();
			$display("test %0d done", t);
		end
		irq_test(32'h2);
		$display("test resume done");
		irq_test(32'h4);
		$display("test abandon done");
		finish_test();
	end
endmodule // testbench
`default_nettype wire
